// ==== rtl/io_bank_pkg.sv ====
/*
  Constants of the text/display processor I/O register bank: offsets,
  reset values, field positions and derived geometry figures.
  Assumes a 16-bit CPU address space and 8-bit data.
*/
package io_bank_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [15:0] OFS_SYSTEM_CONTROL     = 16'h0200;
  localparam logic [15:0] OFS_POWER_DOWN_CONTROL = 16'h0202;
  localparam logic [15:0] OFS_INTERFACE_SETUP    = 16'h0213;
  localparam logic [15:0] OFS_BLANK_PULSE_END    = 16'h0251;
  localparam logic [15:0] OFS_BLANK_PULSE_BEGIN  = 16'h0252;
  localparam logic [15:0] OFS_DISPLAY_SETUP_ONE  = 16'h0254;
  localparam logic [15:0] OFS_DISPLAY_SETUP_TWO  = 16'h0255;
  localparam logic [15:0] OFS_PIXEL_PRIORITY     = 16'h025a;
  localparam logic [15:0] OFS_FAST_BLANK_COLOR   = 16'h025b;

  // Boot source of the system control register
  localparam logic [15:0] BOOT_CTRL_ADDR = 16'hfff9;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_SYSTEM_CONTROL     = 8'h00;
  localparam logic [7:0] RST_POWER_DOWN_CONTROL = 8'h00;
  localparam logic [7:0] RST_INTERFACE_SETUP    = 8'h00;
  localparam logic [7:0] RST_BLANK_PULSE_END    = 8'h07;
  localparam logic [7:0] RST_BLANK_PULSE_BEGIN  = 8'h00;
  localparam logic [7:0] RST_DISPLAY_SETUP_ONE  = 8'h60;
  localparam logic [7:0] RST_DISPLAY_SETUP_TWO  = 8'h0d;
  localparam logic [7:0] RST_PIXEL_PRIORITY     = 8'h35;
  localparam logic [7:0] RST_FAST_BLANK_COLOR   = 8'h00;
  localparam logic [7:0] READ_FILL              = 8'h00;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTL_CPU_OFF    = 7;
  localparam int CTL_PRAM_OFF   = 6;
  localparam int CTL_PROM_OFF   = 5;
  localparam int CTL_CROM_OFF   = 4;
  localparam int CTL_DMA_OFF    = 3;
  localparam int CTL_IOPAGE_OFF = 2;
  localparam int CTL_TEST_ON    = 1;
  localparam int CTL_BURNIN     = 0;
  localparam int PD_DIGITAL     = 2;
  localparam int PD_ANALOG      = 1;
  localparam int IF_STANDBY_EN  = 1;
  localparam int D1_FONT1_ONLY  = 7;
  localparam int D1_OSD_EN      = 6;
  localparam int D1_FLASH       = 5;
  localparam int D1_CELL13      = 4;
  localparam int D1_SCROLL_HI   = 3;
  localparam int D2_CODE_CHARSET = 7;
  localparam int D2_CLK_SLOW    = 3;
  localparam int D2_FPTR10      = 2;
  localparam int D2_FPTR16      = 1;
  localparam int D2_CELL10      = 0;
  localparam int PR_SHADOW_HI   = 5;
  localparam int PR_SHADOW_LO   = 3;
  localparam int PR_NORMAL_HI   = 2;
  localparam int FB_COLOR4      = 7;
  localparam int FB_COLOR3      = 6;
  localparam int FB_INVERT      = 4;
  localparam int FB_STATUS      = 0;
  localparam logic [7:0] FB_WRITE_MASK = 8'hd0;

  // ---------------------------------------------------------------
  // Geometry figures
  // ---------------------------------------------------------------
  localparam logic [7:0] FONT2_FIRST_CODE = 8'h20;
  localparam logic [3:0] CELL_LINES_8     = 4'h8;
  localparam logic [3:0] CELL_LINES_10    = 4'ha;
  localparam logic [3:0] CELL_LINES_13    = 4'hd;
  localparam logic [4:0] FPTR_LINES_8     = 5'h08;
  localparam logic [4:0] FPTR_LINES_10    = 5'h0a;
  localparam logic [4:0] FPTR_LINES_16    = 5'h10;

endpackage

// ==== rtl/boot_load_if.sv ====
/*
  Carrier between the boot loader and the register bank core.
  Assumes both ends on core_clk.
*/
`timescale 1ns/1ps

interface boot_load_if;
  logic       done;
  logic [7:0] data;

  modport loader (output done, output data);
  modport core   (input done, input data);
endinterface

// ==== rtl/level_sync.sv ====
/*
  Two-flop synchroniser for asynchronous level inputs.
  Assumes the input is a slow level; no pulse capture.
*/
`timescale 1ns/1ps

module level_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // Levels
  input  wire logic [W-1:0] async_in,
  output wire logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] first;
    logic [W-1:0] second;
  } sync_state_type;

  sync_state_type q;
  sync_state_type d;

  always_comb begin
    d.first  = async_in;
    d.second = q.first;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.second;

endmodule

// ==== rtl/ctrl_boot_loader.sv ====
/*
  Fetches the boot byte of the system control register after reset.
  Assumes the memory answers a held read with a one-cycle valid pulse.
*/
`timescale 1ns/1ps

module ctrl_boot_loader (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Memory read port
  output wire logic [15:0] mem_addr,
  output wire logic        mem_rd,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        mem_valid,
  // Result
  boot_load_if.loader      boot
);

  typedef enum logic [1:0] {
    LD_REQ  = 2'b00,
    LD_DONE = 2'b01
  } load_state_type;

  typedef struct packed {
    load_state_type st;
    logic [7:0]     data;
  } loader_type;

  loader_type q;
  loader_type d;

  always_comb begin
    d = q;
    case (q.st)
      LD_REQ: begin
        if (mem_valid) begin
          d.data = mem_rdata;
          d.st   = LD_DONE;
        end
      end
      LD_DONE: begin
        d.st = LD_DONE;
      end
      default: begin
        d.st = LD_REQ;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      q.st   <= LD_REQ;
      q.data <= 8'h00;
    end else begin
      q <= d;
    end
  end

  assign mem_addr  = io_bank_pkg::BOOT_CTRL_ADDR;
  assign mem_rd    = (q.st == LD_REQ);
  assign boot.done = (q.st == LD_DONE);
  assign boot.data = q.data;

endmodule

// ==== rtl/text_processor_io_registers.sv ====
/*
  I/O register bank of the text/display processor: unit enables, test
  and standby control, blanking window, OSD geometry, priority codes and
  fast-blanking colour. Two access ports: the embedded CPU and the host
  path already decoded from the I2C CPU subaddresses.
  Assumes single core_clk domain; test_pin is asynchronous.
*/
`timescale 1ns/1ps

module text_processor_io_registers (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Embedded CPU memory-mapped port
  input  wire logic [15:0] cpu_addr,
  input  wire logic        cpu_wr,
  input  wire logic        cpu_rd,
  input  wire logic [7:0]  cpu_wdata,
  output wire logic        cpu_ready,
  output wire logic        cpu_ack,
  output wire logic [7:0]  cpu_rdata,
  // Host port behind the I2C CPU subaddresses
  input  wire logic        host_valid,
  input  wire logic        host_write,
  input  wire logic [15:0] host_addr,
  input  wire logic [7:0]  host_wdata,
  output wire logic        host_ready,
  output wire logic        host_ack,
  output wire logic [7:0]  host_rdata,
  // Boot memory read
  output wire logic [15:0] mem_addr,
  output wire logic        mem_rd,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        mem_valid,
  // Pins and events
  input  wire logic        test_pin,
  input  wire logic        fast_blanking_event,
  input  wire logic [7:0]  osd_char_code,
  // Unit control
  output wire logic        init_done,
  output wire logic        cpu_disable,
  output wire logic        program_ram_disable,
  output wire logic        program_rom_disable,
  output wire logic        char_rom_disable,
  output wire logic        dma_disable,
  output wire logic        io_page_disable,
  output wire logic        test_mode,
  output wire logic        burnin_mode,
  output wire logic        power_down_digital,
  output wire logic        power_down_analog,
  output wire logic        standby_enable,
  // Display control
  output wire logic [7:0]  blank_end_chars,
  output wire logic [7:0]  blank_begin_chars,
  output wire logic        osd_use_font2,
  output wire logic        osd_enable,
  output wire logic        osd_flash_active,
  output wire logic [3:0]  osd_first_scanline,
  output wire logic        osd_code_selects_charset,
  output wire logic        display_clock_slow,
  output wire logic [3:0]  cell_height_lines,
  output wire logic [4:0]  font_pointer_lines,
  output wire logic [2:0]  shadow_priority,
  output wire logic [2:0]  normal_priority,
  output wire logic [1:0]  fast_blanking_color,
  output wire logic        fast_blanking_invert
);

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------
  boot_load_if boot ();

  logic test_pin_s;

  ctrl_boot_loader u_loader (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .mem_addr  (mem_addr),
    .mem_rd    (mem_rd),
    .mem_rdata (mem_rdata),
    .mem_valid (mem_valid),
    .boot      (boot.loader)
  );

  level_sync #(.W(1)) u_test_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in (test_pin),
    .sync_out (test_pin_s)
  );

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] pdown;
    logic [7:0] iface;
    logic [7:0] bend;
    logic [7:0] bbegin;
    logic [7:0] disp1;
    logic [7:0] disp2;
    logic [7:0] prio;
    logic [7:0] fb;
    logic       loaded;
    logic [7:0] cpu_rdata;
    logic [7:0] host_rdata;
    logic       cpu_ack;
    logic       host_ack;
    logic       font2;
  } bank_type;

  bank_type q;
  bank_type d;

  // ---------------------------------------------------------------
  // Access arbitration: CPU first, host waits
  // ---------------------------------------------------------------
  logic        cpu_take;
  logic        host_take;
  logic        acc_take;
  logic        acc_wr;
  logic [15:0] acc_addr;
  logic [7:0]  acc_wdata;
  logic [7:0]  rd_value;
  logic        burnin_now;

  assign cpu_ready  = q.loaded;
  assign host_ready = q.loaded && !(cpu_wr || cpu_rd);
  assign cpu_take   = q.loaded && (cpu_wr || cpu_rd);
  assign host_take  = host_valid && host_ready;
  assign acc_take   = cpu_take || host_take;
  assign acc_wr     = cpu_take ? cpu_wr : host_write;
  assign acc_addr   = cpu_take ? cpu_addr : host_addr;
  assign acc_wdata  = cpu_take ? cpu_wdata : host_wdata;

  assign burnin_now = q.ctrl[io_bank_pkg::CTL_BURNIN] && test_pin_s;

  // Read data; write-only and unmapped offsets give zero
  always_comb begin
    rd_value = io_bank_pkg::READ_FILL;
    case (acc_addr)
      io_bank_pkg::OFS_SYSTEM_CONTROL: begin
        rd_value = {q.ctrl[7:1], burnin_now};
      end
      io_bank_pkg::OFS_FAST_BLANK_COLOR: begin
        rd_value = q.fb;
      end
      default: begin
        rd_value = io_bank_pkg::READ_FILL;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    d          = q;
    d.cpu_ack  = cpu_take;
    d.host_ack = host_take;
    d.font2    = !q.disp1[io_bank_pkg::D1_FONT1_ONLY] &&
                 (osd_char_code >= io_bank_pkg::FONT2_FIRST_CODE);
    if (!q.loaded && boot.done) begin
      d.ctrl   = boot.data;
      d.loaded = 1'b1;
    end
    if (cpu_take && cpu_rd) begin
      d.cpu_rdata = rd_value;
    end
    if (host_take && !host_write) begin
      d.host_rdata = rd_value;
    end
    if (acc_take && !acc_wr && acc_addr == io_bank_pkg::OFS_FAST_BLANK_COLOR) begin
      d.fb[io_bank_pkg::FB_STATUS] = 1'b0;
    end
    if (acc_take && acc_wr) begin
      case (acc_addr)
        io_bank_pkg::OFS_SYSTEM_CONTROL: begin
          d.ctrl = acc_wdata;
        end
        io_bank_pkg::OFS_POWER_DOWN_CONTROL: begin
          d.pdown = acc_wdata;
        end
        io_bank_pkg::OFS_INTERFACE_SETUP: begin
          d.iface = acc_wdata;
        end
        io_bank_pkg::OFS_BLANK_PULSE_END: begin
          d.bend = acc_wdata;
        end
        io_bank_pkg::OFS_BLANK_PULSE_BEGIN: begin
          d.bbegin = acc_wdata;
        end
        io_bank_pkg::OFS_DISPLAY_SETUP_ONE: begin
          d.disp1 = acc_wdata;
        end
        io_bank_pkg::OFS_DISPLAY_SETUP_TWO: begin
          d.disp2 = acc_wdata;
        end
        io_bank_pkg::OFS_PIXEL_PRIORITY: begin
          d.prio = acc_wdata;
        end
        io_bank_pkg::OFS_FAST_BLANK_COLOR: begin
          d.fb = (acc_wdata & io_bank_pkg::FB_WRITE_MASK) |
                 (q.fb & ~io_bank_pkg::FB_WRITE_MASK);
        end
        default: begin
          d.ctrl = d.ctrl;
        end
      endcase
    end
    // Event beats a same-cycle read clear
    if (fast_blanking_event) begin
      d.fb[io_bank_pkg::FB_STATUS] = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      q.ctrl       <= io_bank_pkg::RST_SYSTEM_CONTROL;
      q.pdown      <= io_bank_pkg::RST_POWER_DOWN_CONTROL;
      q.iface      <= io_bank_pkg::RST_INTERFACE_SETUP;
      q.bend       <= io_bank_pkg::RST_BLANK_PULSE_END;
      q.bbegin     <= io_bank_pkg::RST_BLANK_PULSE_BEGIN;
      q.disp1      <= io_bank_pkg::RST_DISPLAY_SETUP_ONE;
      q.disp2      <= io_bank_pkg::RST_DISPLAY_SETUP_TWO;
      q.prio       <= io_bank_pkg::RST_PIXEL_PRIORITY;
      q.fb         <= io_bank_pkg::RST_FAST_BLANK_COLOR;
      q.loaded     <= 1'b0;
      q.cpu_rdata  <= 8'h00;
      q.host_rdata <= 8'h00;
      q.cpu_ack    <= 1'b0;
      q.host_ack   <= 1'b0;
      q.font2      <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign cpu_ack    = q.cpu_ack;
  assign cpu_rdata  = q.cpu_rdata;
  assign host_ack   = q.host_ack;
  assign host_rdata = q.host_rdata;
  assign init_done  = q.loaded;

  assign cpu_disable         = q.ctrl[io_bank_pkg::CTL_CPU_OFF];
  assign program_ram_disable = q.ctrl[io_bank_pkg::CTL_PRAM_OFF];
  assign program_rom_disable = q.ctrl[io_bank_pkg::CTL_PROM_OFF];
  assign char_rom_disable    = q.ctrl[io_bank_pkg::CTL_CROM_OFF];
  assign dma_disable         = q.ctrl[io_bank_pkg::CTL_DMA_OFF];
  assign io_page_disable     = q.ctrl[io_bank_pkg::CTL_IOPAGE_OFF];
  assign test_mode           = q.ctrl[io_bank_pkg::CTL_TEST_ON];
  assign burnin_mode         = burnin_now;
  assign power_down_digital  = q.pdown[io_bank_pkg::PD_DIGITAL];
  assign power_down_analog   = q.pdown[io_bank_pkg::PD_ANALOG];
  assign standby_enable      = q.iface[io_bank_pkg::IF_STANDBY_EN] &&
                               q.pdown[io_bank_pkg::PD_DIGITAL];

  assign blank_end_chars     = q.bend;
  assign blank_begin_chars   = q.bbegin;
  assign osd_use_font2       = q.font2;
  assign osd_enable          = q.disp1[io_bank_pkg::D1_OSD_EN];
  assign osd_flash_active    = q.disp1[io_bank_pkg::D1_FLASH];
  assign osd_first_scanline  = q.disp1[io_bank_pkg::D1_SCROLL_HI:0];
  assign osd_code_selects_charset = q.disp2[io_bank_pkg::D2_CODE_CHARSET];
  assign display_clock_slow  = q.disp2[io_bank_pkg::D2_CLK_SLOW];

  // Cell height and font pointer step
  assign cell_height_lines =
    q.disp2[io_bank_pkg::D2_CELL10] ? io_bank_pkg::CELL_LINES_10 :
    q.disp1[io_bank_pkg::D1_CELL13] ? io_bank_pkg::CELL_LINES_13 :
                                      io_bank_pkg::CELL_LINES_8;
  assign font_pointer_lines =
    q.disp2[io_bank_pkg::D2_FPTR10] ? io_bank_pkg::FPTR_LINES_10 :
    q.disp2[io_bank_pkg::D2_FPTR16] ? io_bank_pkg::FPTR_LINES_16 :
                                      io_bank_pkg::FPTR_LINES_8;

  assign shadow_priority = q.prio[io_bank_pkg::PR_SHADOW_HI:io_bank_pkg::PR_SHADOW_LO];
  assign normal_priority = q.prio[io_bank_pkg::PR_NORMAL_HI:0];
  assign fast_blanking_color  = {q.fb[io_bank_pkg::FB_COLOR4],
                                 q.fb[io_bank_pkg::FB_COLOR3]};
  assign fast_blanking_invert = q.fb[io_bank_pkg::FB_INVERT];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking chk_cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  chk_boot_capture:
    assert property ($rose(q.loaded) |-> q.ctrl == $past(boot.data))
    else $error("control register not loaded from boot byte");

  chk_reset_values:
    assert property ($rose(rst_n) |-> blank_end_chars == 8'h07 && blank_begin_chars == 8'h00
                     && osd_enable && osd_flash_active && display_clock_slow
                     && shadow_priority == 3'b110 && normal_priority == 3'b101)
    else $error("reset values wrong after reset");

  chk_wo_read_zero:
    assert property (cpu_take && cpu_rd && cpu_addr == io_bank_pkg::OFS_BLANK_PULSE_END
                     |=> cpu_ack && cpu_rdata == 8'h00)
    else $error("write-only register returned data");

  chk_burnin_gate:
    assert property (burnin_mode |-> $past(test_pin, 2) && q.ctrl[io_bank_pkg::CTL_BURNIN])
    else $error("burn-in active without test pin");

  chk_standby_gate:
    assert property (!power_down_digital |-> !standby_enable)
    else $error("standby enabled without digital power-off");

  chk_fb_read_clear:
    assert property (cpu_take && cpu_rd && cpu_addr == io_bank_pkg::OFS_FAST_BLANK_COLOR
                     && !fast_blanking_event |=> !q.fb[0] && cpu_rdata[0] == $past(q.fb[0]))
    else $error("fast-blanking status not returned then cleared");

  chk_fb_event_wins:
    assert property (fast_blanking_event |=> q.fb[0])
    else $error("fast-blanking event lost");

  chk_font_switch:
    assert property (!q.disp1[7] && osd_char_code >= 8'h20 |=> osd_use_font2)
    else $error("font two not selected");

  chk_cell_height:
    assert property (q.disp2[0] |-> cell_height_lines == 4'ha)
    else $error("cell height not ten lines");

  chk_fb_color_write:
    assert property (cpu_take && cpu_wr && cpu_addr == io_bank_pkg::OFS_FAST_BLANK_COLOR
                     |=> fast_blanking_color == $past(cpu_wdata[7:6])
                     && fast_blanking_invert == $past(cpu_wdata[4]))
    else $error("fast-blanking colour not taken from write");

endmodule

// ==== tb/boot_mem_model.sv ====
/*
  Boot memory model answering the control boot byte read.
  Assumes a held mem_rd and a one-cycle valid answer.
*/
`timescale 1ns/1ps

module boot_mem_model #(
  parameter logic [7:0] BOOT_BYTE = 8'h04,
  parameter int         DELAY     = 3
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Boot read port
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_rd,
  output logic      [7:0]  mem_rdata,
  output logic             mem_valid
);
  int cnt = 0;
  initial mem_rdata = 8'h00;
  initial mem_valid = 1'b0;
  always @(posedge core_clk) begin
    mem_valid <= 1'b0;
    // Nothing held between answers
    mem_rdata <= ~mem_rdata;
    if (!rst_n || !mem_rd) begin
      cnt <= 0;
    end else if (mem_addr === 16'hfff9) begin
      cnt <= cnt + 1;
      if (cnt == DELAY) begin
        mem_valid <= 1'b1;
        mem_rdata <= BOOT_BYTE;
      end
    end
  end
endmodule

// ==== tb/testbench.sv ====
/*
  Self-checking bench of the I/O register bank.
  Assumes the boot memory model on the boot read port.
*/
`timescale 1ns/1ps

module testbench;
  logic core_clk = 0, rst_n = 0, cpu_wr = 0, cpu_rd = 0, host_valid = 0;
  logic host_write = 0, test_pin = 0, fast_blanking_event = 0;
  logic [15:0] cpu_addr = 0, host_addr = 0, mem_addr;
  logic [7:0] cpu_wdata = 0, host_wdata = 0, osd_char_code = 0, rd;
  logic [7:0] cpu_rdata, host_rdata, mem_rdata, blank_end_chars, blank_begin_chars;
  logic cpu_ack, host_ack, mem_rd, mem_valid, init_done, cpu_disable;
  logic io_page_disable, test_mode, burnin_mode, power_down_digital;
  logic power_down_analog, standby_enable, osd_use_font2, osd_enable;
  logic osd_flash_active, osd_code_selects_charset, display_clock_slow;
  logic fast_blanking_invert;
  logic cpu_ready, host_ready, program_ram_disable, program_rom_disable;
  logic char_rom_disable, dma_disable;
  logic [3:0] osd_first_scanline, cell_height_lines;
  logic [4:0] font_pointer_lines;
  logic [2:0] shadow_priority, normal_priority;
  logic [1:0] fast_blanking_color;
  int fail_count = 0, n_compared = 0;

  always #10 core_clk = ~core_clk;

  text_processor_io_registers i_text_processor_io_registers (
    .core_clk, .rst_n, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata,
    .cpu_ready, .cpu_ack, .cpu_rdata, .host_valid, .host_write,
    .host_addr, .host_wdata, .host_ready, .host_ack, .host_rdata,
    .mem_addr, .mem_rd, .mem_rdata, .mem_valid, .test_pin,
    .fast_blanking_event, .osd_char_code, .init_done, .cpu_disable,
    .program_ram_disable, .program_rom_disable, .char_rom_disable,
    .dma_disable, .io_page_disable, .test_mode, .burnin_mode,
    .power_down_digital, .power_down_analog, .standby_enable,
    .blank_end_chars, .blank_begin_chars, .osd_use_font2, .osd_enable,
    .osd_flash_active, .osd_first_scanline, .osd_code_selects_charset,
    .display_clock_slow, .cell_height_lines, .font_pointer_lines,
    .shadow_priority, .normal_priority, .fast_blanking_color,
    .fast_blanking_invert
  );

  boot_mem_model i_boot_mem_model (
    .core_clk, .rst_n, .mem_addr, .mem_rd, .mem_rdata, .mem_valid
  );

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic end_sim;
    if (fail_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cpu(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk);
    {cpu_wr, cpu_rd, cpu_addr, cpu_wdata} = {w, !w, a, d};
    @(negedge core_clk);
    {cpu_wr, cpu_rd} = 2'b00;
    chk("cpu_ack", 8'(cpu_ack), 8'h01);
    rd = cpu_rdata;
  endtask

  task automatic host(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk);
    {host_valid, host_write, host_addr, host_wdata} = {1'b1, w, a, d};
    @(negedge core_clk);
    host_valid = 1'b0;
    chk("host_ack", 8'(host_ack), 8'h01);
    rd = host_rdata;
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(negedge core_clk);
    chk("refused", 8'({cpu_ready, host_ready, init_done}), 8'h00);
    rst_n = 1;
    repeat (8) @(negedge core_clk);
    chk("init_done", 8'(init_done), 8'h01);
    chk("ready", 8'({cpu_ready, host_ready}), 8'h03);
    chk("blank_end", blank_end_chars, 8'h07);
    chk("blank_begin", blank_begin_chars, 8'h00);
    chk("osd_on", 8'({osd_enable, osd_flash_active}), 8'h03);
    chk("clk_slow", 8'(display_clock_slow), 8'h01);
    chk("fptr", 8'(font_pointer_lines), 8'h0a);
    chk("cell", 8'(cell_height_lines), 8'h0a);
    chk("prio", 8'({shadow_priority, normal_priority}), 8'h35);
    chk("io_page", 8'(io_page_disable), 8'h01);
    cpu(0, 16'h0200, 8'h00);
    chk("ctrl_boot", rd, 8'h04);
    cpu(1, 16'h0200, 8'h03);
    chk("test", 8'({test_mode, burnin_mode, io_page_disable}), 8'h04);
    cpu(0, 16'h0200, 8'h00);
    chk("ctrl_rd0", rd, 8'h02);
    test_pin = 1;
    repeat (4) @(negedge core_clk);
    chk("burnin", 8'(burnin_mode), 8'h01);
    cpu(0, 16'h0200, 8'h00);
    chk("ctrl_rd1", rd, 8'h03);
    cpu(1, 16'h0200, 8'h7c);
    chk("units", 8'({cpu_disable, program_ram_disable, program_rom_disable,
                     char_rom_disable, dma_disable, io_page_disable}), 8'h1f);
    cpu(0, 16'h0200, 8'h00);
    chk("ctrl_rd2", rd, 8'h7c);
    cpu(1, 16'h0200, 8'h80);
    chk("cpu_off", 8'({cpu_disable, test_mode}), 8'h02);
    cpu(1, 16'h0213, 8'h02);
    cpu(1, 16'h0202, 8'h02);
    chk("stby_a", 8'({power_down_digital, power_down_analog, standby_enable}), 8'h02);
    cpu(1, 16'h0202, 8'h04);
    chk("stby_d", 8'({power_down_digital, power_down_analog, standby_enable}), 8'h05);
    cpu(0, 16'h0251, 8'h00);
    chk("wo_read", rd, 8'h00);
    cpu(0, 16'h0300, 8'h00);
    chk("unmapped", rd, 8'h00);
    cpu(1, 16'h0254, 8'h15);
    chk("disp1", {osd_enable, osd_flash_active, 2'b00, osd_first_scanline}, 8'h05);
    chk("cell10", 8'(cell_height_lines), 8'h0a);
    cpu(1, 16'h0255, 8'h82);
    chk("disp2", 8'({osd_code_selects_charset, display_clock_slow, cell_height_lines}), 8'h2d);
    chk("fptr16", 8'(font_pointer_lines), 8'h10);
    cpu(1, 16'h0255, 8'h00);
    cpu(1, 16'h0254, 8'h00);
    chk("cell8", 8'({font_pointer_lines, cell_height_lines}), 8'h88);
    osd_char_code = 8'h20;
    repeat (2) @(negedge core_clk);
    chk("font2", 8'(osd_use_font2), 8'h01);
    osd_char_code = 8'h1f;
    repeat (2) @(negedge core_clk);
    chk("font1", 8'(osd_use_font2), 8'h00);
    cpu(1, 16'h0254, 8'h80);
    osd_char_code = 8'h20;
    repeat (2) @(negedge core_clk);
    chk("font1_only", 8'(osd_use_font2), 8'h00);
    cpu(1, 16'h025a, 8'h1a);
    chk("prio_w", 8'({shadow_priority, normal_priority}), 8'h1a);
    cpu(1, 16'h025b, 8'hd0);
    chk("fb_out", 8'({fast_blanking_color, fast_blanking_invert}), 8'h07);
    fast_blanking_event = 1;
    @(negedge core_clk);
    fast_blanking_event = 0;
    cpu(0, 16'h025b, 8'h00);
    chk("fb_rd1", rd, 8'hd1);
    cpu(0, 16'h025b, 8'h00);
    chk("fb_rd2", rd, 8'hd0);
    host(1, 16'h0251, 8'h20);
    chk("host_end", blank_end_chars, 8'h20);
    host(1, 16'h0252, 8'h03);
    chk("host_begin", blank_begin_chars, 8'h03);
    host(0, 16'h0200, 8'h00);
    chk("host_ctrl", rd, 8'h80);
    rst_n = 0;
    repeat (3) @(negedge core_clk);
    rst_n = 1;
    repeat (8) @(negedge core_clk);
    chk("re_init", 8'({init_done, io_page_disable}), 8'h03);
    chk("re_end", blank_end_chars, 8'h07);
    end_sim();
  end

  initial begin
    #400000;
    fail_count++;
    end_sim();
  end
endmodule
